// >>> logic/lpf_pkg.sv
// Constants shared by the long-packet radio FIFO core
package lpf_pkg;
    localparam int FIFO_DEPTH = 64;
    localparam int FIFO_AW = 6;
    localparam int CNT_W = 7;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_THR = 8'h04;
    localparam logic [7:0] REG_IRQ_EN = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
    localparam logic [7:0] REG_PKT_LEN = 8'h10;
    localparam logic [7:0] REG_LEVEL = 8'h14;
    // Field positions
    localparam int CTRL_TX_START = 0;
    localparam int CTRL_RX_START = 1;
    localparam int THR_TX_LSB = 0;
    localparam int THR_RX_LSB = 8;
    localparam int IRQ_TX_AE = 0;
    localparam int IRQ_TX_SENT = 1;
    localparam int IRQ_RX_AF = 2;
    localparam int IRQ_RX_DONE = 3;
    localparam int LVL_TX_LSB = 0;
    localparam int LVL_RX_LSB = 8;
    localparam int LVL_TX_BUSY = 16;
    localparam int LVL_RX_BUSY = 17;
    // Reset values
    localparam logic [6:0] THR_TX_RST = 7'h20;
    localparam logic [6:0] THR_RX_RST = 7'h20;
    localparam logic [3:0] IRQ_EN_RST = 4'h0;
    localparam logic [15:0] PKT_LEN_RST = 16'h0040;
    // Serial commands, first byte of a frame
    localparam logic [7:0] CMD_TX_WRITE = 8'h66;
    localparam logic [7:0] CMD_RX_READ = 8'h77;
endpackage

// >>> logic/lpf_byte_fifo.sv
// 64-entry byte FIFO built from flip-flops
`timescale 1ns/1ps
`default_nettype none
module lpf_byte_fifo
    import lpf_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    // Write side
    input wire logic push_i,
    input wire logic [7:0] din_i,
    // Read side
    input wire logic pop_i,
    output logic [7:0] dout_o,
    // Fill state
    output logic [lpf_pkg::CNT_W-1:0] count_o,
    output logic full_o,
    output logic empty_o
);
    logic [7:0] mem_r [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic do_push, do_pop;

    assign full_o = (cnt_r == CNT_W'(FIFO_DEPTH));
    assign empty_o = (cnt_r == '0);
    assign count_o = cnt_r;
    assign dout_o = mem_r[rptr_r];
    // Pushes into a full FIFO are dropped
    assign do_push = push_i & ~full_o;
    assign do_pop = pop_i & ~empty_o;

    always_comb begin
        wptr_nxt = wptr_r + FIFO_AW'(do_push);
        rptr_nxt = rptr_r + FIFO_AW'(do_pop);
        cnt_nxt = cnt_r + CNT_W'(do_push) - CNT_W'(do_pop);
        if (flush_i) begin
            wptr_nxt = '0;
            rptr_nxt = '0;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else begin
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_ent
        always_ff @(posedge clk_i) begin
            if (do_push && wptr_r == FIFO_AW'(i)) begin
                mem_r[i] <= din_i;
            end
        end
    end

    property p_cnt_max;
        @(posedge clk_i) disable iff (rst_i) cnt_r <= CNT_W'(FIFO_DEPTH);
    endproperty
    a_cnt_max: assert property (p_cnt_max) else $error("fifo count above capacity");
    property p_push_inc;
        @(posedge clk_i) disable iff (rst_i)
            (push_i && !full_o && !pop_i && !flush_i) |=> cnt_r == $past(cnt_r) + 7'h1;
    endproperty
    a_push_inc: assert property (p_push_inc) else $error("push did not raise count");
endmodule
`default_nettype wire

// >>> logic/lpf_radio_core.sv
// Long-packet radio FIFO core: serial data port, register bus, interrupts
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lpf_radio_core
    import lpf_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Host serial port and pins
    input wire logic spi_sclk_i,
    input wire logic spi_mosi_i,
    input wire logic serial_chip_select_n_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    input wire logic shutdown_input_i,
    output logic interrupt_request_n_o,
    // Modem byte streams
    output logic [7:0] tx_data_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_valid_i
);
    import lpf_pkg::*;

    typedef enum logic [3:0] {
        SP_IDLE = 4'b0001,
        SP_CMD = 4'b0010,
        SP_WR = 4'b0100,
        SP_RD = 4'b1000
    } spi_st_e;

    // Pin synchronisers: {shutdown, cs_n, mosi, sclk}
    logic [3:0] sync1_r, sync2_r, sync3_r, pin_r, pin_nxt, agree;
    always_comb begin
        agree = ~(sync2_r ^ sync3_r);
        pin_nxt = (pin_r & ~agree) | (sync2_r & agree);
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= 4'h4;
            sync2_r <= 4'h4;
            sync3_r <= 4'h4;
            pin_r <= 4'h4;
        end else begin
            sync1_r <= {shutdown_input_i, serial_chip_select_n_i, spi_mosi_i, spi_sclk_i};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pin_r <= pin_nxt;
        end
    end
    logic sclk_rise, sclk_fall, frame, shutdown_input;
    assign sclk_rise = pin_nxt[0] & ~pin_r[0];
    assign sclk_fall = ~pin_nxt[0] & pin_r[0];
    assign frame = ~pin_r[2];
    assign shutdown_input = pin_r[3];

    // FIFOs
    logic tx_push, tx_pop, tx_empty, rx_push, rx_pop, rx_empty;
    logic [7:0] tx_din, rx_dout;
    logic [CNT_W-1:0] tx_cnt, rx_cnt;
    lpf_byte_fifo u_tx_fifo (
        .clk_i(clk_i), .rst_i(rst_i), .flush_i(shutdown_input),
        .push_i(tx_push), .din_i(tx_din), .pop_i(tx_pop), .dout_o(tx_data_o),
        .count_o(tx_cnt), .full_o(), .empty_o(tx_empty)
    );
    lpf_byte_fifo u_rx_fifo (
        .clk_i(clk_i), .rst_i(rst_i), .flush_i(shutdown_input),
        .push_i(rx_push), .din_i(rx_data_i), .pop_i(rx_pop), .dout_o(rx_dout),
        .count_o(rx_cnt), .full_o(), .empty_o(rx_empty)
    );

    // Serial slave, mode 0, MSB first
    spi_st_e st_r, st_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [7:0] shin_r, shin_nxt, shout_r, shout_nxt, byte_in;
    logic hold_r, hold_nxt, pend_r, pend_nxt;
    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        shin_nxt = shin_r;
        shout_nxt = shout_r;
        hold_nxt = hold_r;
        pend_nxt = pend_r;
        tx_push = 1'b0;
        rx_pop = 1'b0;
        byte_in = {shin_r[6:0], pin_r[1]};
        tx_din = byte_in;
        if (!frame || shutdown_input) begin
            st_nxt = SP_IDLE;
            bit_nxt = '0;
            shout_nxt = '0;
            hold_nxt = 1'b0;
            pend_nxt = 1'b0;
        end else if (st_r == SP_IDLE) begin
            st_nxt = SP_CMD;
        end else if (sclk_rise) begin
            shin_nxt = byte_in;
            bit_nxt = bit_r + 3'h1;
            // pop once the host clocks its first bit
            if (st_r == SP_RD && bit_r == 3'h0 && pend_r) begin
                rx_pop = 1'b1;
                pend_nxt = 1'b0;
            end
            if (bit_r == 3'h7) begin
                unique case (st_r)
                    SP_CMD: begin
                        if (byte_in == CMD_TX_WRITE) begin
                            st_nxt = SP_WR;
                        end else if (byte_in == CMD_RX_READ) begin
                            st_nxt = SP_RD;
                        end
                    end
                    SP_WR: tx_push = 1'b1;
                    SP_RD: ;
                    SP_IDLE: ;
                endcase
                // Peek only: a frame cut after the last byte must lose nothing
                if ((st_r == SP_CMD && byte_in == CMD_RX_READ) || st_r == SP_RD) begin
                    shout_nxt = rx_empty ? 8'h00 : rx_dout;
                    pend_nxt = ~rx_empty;
                    hold_nxt = 1'b1;
                end
            end
        end else if (sclk_fall) begin
            if (hold_r) begin
                hold_nxt = 1'b0;
            end else begin
                shout_nxt = {shout_r[6:0], 1'b0};
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= SP_IDLE;
            bit_r <= '0;
            shin_r <= '0;
            shout_r <= '0;
            hold_r <= 1'b0;
            pend_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            shin_r <= shin_nxt;
            shout_r <= shout_nxt;
            hold_r <= hold_nxt;
            pend_r <= pend_nxt;
        end
    end
    assign spi_miso_o = shout_r[7];
    assign spi_miso_oe_o = frame;

    // Registers and packet control
    logic ack_r, ack_nxt, wr, tx_act_r, tx_act_nxt, rx_act_r, rx_act_nxt;
    logic ae_prev_r, af_prev_r, ae_lvl, af_lvl, tx_done, rx_done;
    logic [31:0] dat_r, dat_nxt, wmask;
    logic [6:0] thr_tx_r, thr_tx_nxt, thr_rx_r, thr_rx_nxt;
    logic [3:0] en_r, en_nxt, stat_r, stat_nxt, ev;
    logic [15:0] len_r, len_nxt, txn_r, txn_nxt, rxn_r, rxn_nxt;
    logic [31:0] thr_w, len_w;

    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
    assign tx_valid_o = tx_act_r & ~tx_empty;
    assign tx_pop = tx_valid_o & tx_ready_i;
    assign rx_push = rx_act_r & rx_valid_i;
    assign tx_done = tx_pop & (txn_r + 16'h1 == len_r);
    assign rx_done = rx_push & (rxn_r + 16'h1 == len_r);
    assign ae_lvl = tx_cnt <= thr_tx_r;
    assign af_lvl = rx_cnt >= thr_rx_r;
    assign thr_w = (32'({thr_rx_r, 1'b0, thr_tx_r}) & ~wmask) | (wb_dat_i & wmask);
    assign len_w = (32'(len_r) & ~wmask) | (wb_dat_i & wmask);

    always_comb begin
        ev = '0;
        ev[IRQ_TX_AE] = tx_act_r & ae_lvl & ~ae_prev_r;
        ev[IRQ_TX_SENT] = tx_done;
        ev[IRQ_RX_AF] = rx_act_r & af_lvl & ~af_prev_r;
        ev[IRQ_RX_DONE] = rx_done;
        ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
        thr_tx_nxt = thr_tx_r;
        thr_rx_nxt = thr_rx_r;
        en_nxt = en_r;
        len_nxt = len_r;
        stat_nxt = stat_r;
        tx_act_nxt = tx_act_r & ~tx_done;
        rx_act_nxt = rx_act_r & ~rx_done;
        txn_nxt = txn_r + 16'(tx_pop);
        rxn_nxt = rxn_r + 16'(rx_push);
        if (wr && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
            if (wb_dat_i[CTRL_TX_START]) begin
                tx_act_nxt = 1'b1;
                txn_nxt = '0;
            end
            if (wb_dat_i[CTRL_RX_START]) begin
                rx_act_nxt = 1'b1;
                rxn_nxt = '0;
            end
        end
        if (wr && wb_adr_i == REG_THR) begin
            thr_tx_nxt = thr_w[THR_TX_LSB +: 7];
            thr_rx_nxt = thr_w[THR_RX_LSB +: 7];
        end
        if (wr && wb_adr_i == REG_IRQ_EN && wb_sel_i[0]) begin
            en_nxt = wb_dat_i[3:0];
        end
        if (wr && wb_adr_i == REG_PKT_LEN) begin
            len_nxt = len_w[15:0];
        end
        // Write one to clear; a new event in the same cycle wins
        if (wr && wb_adr_i == REG_IRQ_STAT && wb_sel_i[0]) begin
            stat_nxt = stat_nxt & ~wb_dat_i[3:0];
        end
        stat_nxt = stat_nxt | ev;
        if (shutdown_input) begin
            tx_act_nxt = 1'b0;
            rx_act_nxt = 1'b0;
        end
        unique case (wb_adr_i)
            REG_THR: dat_nxt = 32'({thr_rx_r, 1'b0, thr_tx_r});
            REG_IRQ_EN: dat_nxt = 32'(en_r);
            REG_IRQ_STAT: dat_nxt = 32'(stat_r);
            REG_PKT_LEN: dat_nxt = 32'(len_r);
            REG_LEVEL: dat_nxt = 32'({rx_act_r, tx_act_r, 1'b0, rx_cnt, 1'b0, tx_cnt});
            default: dat_nxt = 32'h0000_0000;
        endcase
        if (!ack_nxt) begin
            dat_nxt = dat_r;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= '0;
            thr_tx_r <= THR_TX_RST;
            thr_rx_r <= THR_RX_RST;
            en_r <= IRQ_EN_RST;
            len_r <= PKT_LEN_RST;
            stat_r <= '0;
            tx_act_r <= 1'b0;
            rx_act_r <= 1'b0;
            txn_r <= '0;
            rxn_r <= '0;
            ae_prev_r <= 1'b0;
            af_prev_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            thr_tx_r <= thr_tx_nxt;
            thr_rx_r <= thr_rx_nxt;
            en_r <= en_nxt;
            len_r <= len_nxt;
            stat_r <= stat_nxt;
            tx_act_r <= tx_act_nxt;
            rx_act_r <= rx_act_nxt;
            txn_r <= txn_nxt;
            rxn_r <= rxn_nxt;
            ae_prev_r <= ae_lvl & tx_act_r;
            af_prev_r <= af_lvl & rx_act_r;
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    // pin low while an enabled source pends
    assign interrupt_request_n_o = ~|(stat_r & en_r);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !ack_r;
    endsequence
    sequence s_ans;
        ##1 wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_bus_ans;
        s_req ##0 (wb_cyc_i && wb_stb_i) |-> s_ans;
    endproperty
    a_bus_ans: assert property (p_bus_ans) else $error("bus answer not one cycle");
    property p_tx_ae;
        (tx_act_r && ae_lvl && !ae_prev_r) |=> stat_r[IRQ_TX_AE];
    endproperty
    a_tx_ae: assert property (p_tx_ae) else $error("almost-empty not flagged");
    property p_en_wr;
        (wr && wb_adr_i == REG_IRQ_EN && wb_sel_i[0]) |=> en_r == $past(wb_dat_i[3:0]);
    endproperty
    a_en_wr: assert property (p_en_wr) else $error("enable write lost");
    property p_tx_sent;
        (tx_pop && txn_r + 16'h1 == len_r) |=> (stat_r[IRQ_TX_SENT] && !tx_act_r);
    endproperty
    a_tx_sent: assert property (p_tx_sent) else $error("packet sent not flagged");
    property p_rx_af;
        (rx_act_r && af_lvl && !af_prev_r) |=> stat_r[IRQ_RX_AF];
    endproperty
    a_rx_af: assert property (p_rx_af) else $error("almost-full not flagged");
    property p_rx_done;
        (rx_push && rxn_r + 16'h1 == len_r) |=> (stat_r[IRQ_RX_DONE] && !rx_act_r);
    endproperty
    a_rx_done: assert property (p_rx_done) else $error("packet received not flagged");
    property p_rx_en;
        $rose(en_r[IRQ_RX_AF] && stat_r[IRQ_RX_AF]) |-> !interrupt_request_n_o;
    endproperty
    a_rx_en: assert property (p_rx_en) else $error("almost-full did not reach pin");
    property p_miso_off;
        !frame |-> (!spi_miso_oe_o ##1 !spi_miso_o);
    endproperty
    a_miso_off: assert property (p_miso_off) else $error("output driven outside frame");
    property p_irq;
        (!interrupt_request_n_o && !(wr && (wb_adr_i == REG_IRQ_STAT || wb_adr_i == REG_IRQ_EN)))
            |=> !interrupt_request_n_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt pin released early");
    property p_irq_rel;
        ((stat_r & en_r) == 4'h0) |-> interrupt_request_n_o;
    endproperty
    a_irq_rel: assert property (p_irq_rel) else $error("interrupt pin stuck low");
endmodule
`default_nettype wire

// >>> verif/lpf_host_model.sv
// Host controller model driving the radio's serial port
`timescale 1ns/1ps
`default_nettype none
module lpf_host_model (
    // Serial pins toward the radio
    output logic sclk_o,
    output logic mosi_o,
    output logic cs_n_o,
    input wire logic miso_i,
    input wire logic miso_oe_i
);
    localparam realtime HALF = 62.5;

    // Clock stands low outside frames
    initial begin
        sclk_o = 1'b0;
        mosi_o = 1'b1;
        cs_n_o = 1'b1;
    end

    task automatic frame_begin();
        cs_n_o = 1'b0;
        #(2*HALF);
    endtask

    // Mode 0, MSB first; miso taken at the rising edge
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi_o = tx[i];
            #HALF;
            sclk_o = 1'b1;
            rx[i] = miso_oe_i ? miso_i : 1'bx;
            #HALF;
            sclk_o = 1'b0;
        end
    endtask

    task automatic frame_end();
        #(2*HALF);
        cs_n_o = 1'b1;
        // Released line must not keep a stale value
        mosi_o = ~mosi_o;
    endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the long-packet radio FIFO core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lpf_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic sclk, mosi, cs_n, miso, miso_oe, interrupt_request_n_o, tx_valid_o;
    logic shutdown_input_i = 1'b0;
    logic tx_ready_i = 1'b0;
    logic rx_valid_i = 1'b0;
    logic [7:0] rx_data_i = 8'h00;
    logic [7:0] tx_data_o;
    logic [31:0] rd;
    int n_errors = 0;
    int tests_run = 0;
    int n_popped = 0;
    logic [7:0] ra [5] = '{REG_THR, REG_IRQ_EN, REG_PKT_LEN, REG_LEVEL, 8'h20};
    logic [31:0] rv [5] = '{{17'h0, THR_RX_RST, 1'b0, THR_TX_RST}, {28'h0, IRQ_EN_RST}, {16'h0, PKT_LEN_RST},
                            32'h0, 32'h0};

    always #4 clk_i = ~clk_i;

    lpf_radio_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .spi_sclk_i(sclk), .spi_mosi_i(mosi),
        .serial_chip_select_n_i(cs_n), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
        .shutdown_input_i(shutdown_input_i), .interrupt_request_n_o(interrupt_request_n_o),
        .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
        .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i));

    lpf_host_model host_u (.sclk_o(sclk), .mosi_o(mosi), .cs_n_o(cs_n), .miso_i(miso), .miso_oe_i(miso_oe));

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp, input string what);
        chk_word({31'h0, got}, {31'h0, exp}, what);
    endtask

    // Classic single cycle; returns after the settling half cycle
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(negedge clk_i);
    endtask

    task automatic wait_irq();
        int k;
        k = 0;
        while (interrupt_request_n_o !== 1'b0 && k < 20000) begin
            @(posedge clk_i);
            k++;
        end
        chk_pin(interrupt_request_n_o, 1'b0, "irq pin");
    endtask

    task automatic push_tx(input int n, input int first);
        logic [7:0] q;
        host_u.frame_begin();
        host_u.xfer(CMD_TX_WRITE, q);
        for (int i = 0; i < n; i++) host_u.xfer(8'(first + i), q);
        host_u.frame_end();
    endtask

    task automatic pull_rx(input int n, input int first);
        logic [7:0] q;
        host_u.frame_begin();
        host_u.xfer(CMD_RX_READ, q);
        for (int i = 0; i < n; i++) begin
            host_u.xfer(8'h00, q);
            chk_word({24'h0, q}, {24'h0, 8'(first + i)}, "rx byte");
        end
        host_u.frame_end();
    endtask

    // Modem offers one byte every other cycle
    task automatic feed_rx(input int n, input int first);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            rx_valid_i <= 1'b1;
            rx_data_i <= 8'(first + i);
            @(posedge clk_i);
            rx_valid_i <= 1'b0;
        end
    endtask

    // Modem stalls every other cycle while draining
    always @(posedge clk_i) begin
        tx_ready_i <= ~tx_ready_i;
        if (!rst_i && tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
            chk_word({24'h0, tx_data_o}, {24'h0, 8'(n_popped + 1)}, "tx byte");
            n_popped++;
        end
    end

    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #500000;
        n_errors++;
        $display("wrong value at %0t: timeout", $time);
        conclude();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk_pin(interrupt_request_n_o, 1'b1, "irq idle");
        for (int i = 0; i < 5; i++) begin
            wb_cycle(1'b0, ra[i], 32'h0);
            chk_word(rd, rv[i], "reset value");
        end
        // Long transmit: 80 bytes, threshold 16
        wb_cycle(1'b1, REG_PKT_LEN, 32'd80);
        wb_cycle(1'b1, REG_THR, 32'h1010);
        wb_cycle(1'b1, REG_IRQ_EN, 32'h3);
        push_tx(64, 1);
        wb_cycle(1'b0, REG_LEVEL, 32'h0);
        chk_word(rd & 32'h7f7f, 32'h40, "tx full");
        chk_pin(interrupt_request_n_o, 1'b1, "quiet before start");
        wb_cycle(1'b1, REG_CTRL, 32'h1);
        wait_irq();
        wb_cycle(1'b0, REG_IRQ_STAT, 32'h0);
        chk_word(rd, 32'h1, "almost empty");
        wb_cycle(1'b0, REG_LEVEL, 32'h0);
        chk_word(32'((rd & 32'h7f) <= 16), 32'h1, "level at event");
        wb_cycle(1'b1, REG_IRQ_STAT, 32'h1);
        chk_pin(interrupt_request_n_o, 1'b1, "cleared");
        wb_cycle(1'b1, REG_IRQ_EN, 32'h2);
        push_tx(16, 65);
        wait_irq();
        wb_cycle(1'b0, REG_IRQ_STAT, 32'h0);
        chk_word(rd & 32'h2, 32'h2, "sent");
        chk_word(32'(n_popped), 32'd80, "bytes sent");
        wb_cycle(1'b1, REG_IRQ_STAT, 32'hf);
        // Long receive: 40 bytes, threshold 16
        wb_cycle(1'b1, REG_PKT_LEN, 32'd40);
        wb_cycle(1'b1, REG_IRQ_EN, 32'h8);
        wb_cycle(1'b1, REG_CTRL, 32'h2);
        feed_rx(20, 8'h80);
        wb_cycle(1'b0, REG_IRQ_STAT, 32'h0);
        chk_word(rd, 32'h4, "almost full");
        chk_pin(interrupt_request_n_o, 1'b1, "masked");
        wb_cycle(1'b1, REG_IRQ_EN, 32'hc);
        chk_pin(interrupt_request_n_o, 1'b0, "unmasked");
        pull_rx(16, 8'h80);
        wb_cycle(1'b1, REG_IRQ_STAT, 32'hf);
        chk_pin(interrupt_request_n_o, 1'b1, "rx cleared");
        feed_rx(20, 8'h94);
        wb_cycle(1'b0, REG_IRQ_STAT, 32'h0);
        chk_word(rd, 32'hc, "received");
        wb_cycle(1'b0, REG_LEVEL, 32'h0);
        chk_word(rd & 32'h7f00, 32'h1800, "rx level");
        pull_rx(24, 8'h90);
        wb_cycle(1'b1, REG_IRQ_STAT, 32'hf);
        // Shutdown flushes and silences the serial port
        push_tx(3, 1);
        wb_cycle(1'b0, REG_LEVEL, 32'h0);
        chk_word(rd & 32'h7f, 32'h3, "serial push");
        @(posedge clk_i);
        shutdown_input_i <= 1'b1;
        push_tx(2, 1);
        wb_cycle(1'b0, REG_LEVEL, 32'h0);
        chk_word(rd & 32'h7f7f, 32'h0, "shutdown flush");
        conclude();
    end
endmodule
`default_nettype wire
